// >>> rtl/host_port_pkg.sv
// constants and types for the host port byte map with burst reads
package host_port_pkg;

    // ------------------------------------------------------------
    // host pin side
    // ------------------------------------------------------------
    localparam int unsigned ADDR_W = 6;
    localparam int unsigned DATA_W = 16;
    localparam int unsigned BYTE_W = 8;
    localparam int unsigned NUM_OFFS = 32;
    localparam int unsigned FIFO_SEL_BIT = 5;
    localparam int unsigned PIN_W = 3 + ADDR_W + DATA_W;

    localparam logic [4:0] OFF_CMD = 5'h00;
    localparam logic [4:0] OFF_BCB = 5'h0D;
    localparam logic [4:0] OFF_DATA_PORT = 5'h10;
    localparam logic [4:0] OFF_UNUSED = 5'h11;
    localparam logic [4:0] OFF_LOW_ONLY = 5'h1E;
    localparam logic [4:0] OFF_RESET = 5'h1F;

    localparam int unsigned PAGE_LSB = 6;
    localparam int unsigned PAGE_MSB = 7;
    localparam logic [1:0] PAGE_BCB = 2'h3;
    localparam int unsigned BCB_BIT = 0;
    localparam logic [7:0] OFFS_RESET = 8'h00;
    localparam logic BCB_RESET = 1'b0;

    // strap capture waits for the pin synchroniser to fill after release
    localparam int unsigned SYNC_STAGES = 2;
    localparam logic [1:0] STRAP_TAKE_CYCLES = 2'(SYNC_STAGES + 1);

    // ------------------------------------------------------------
    // apb register map
    // ------------------------------------------------------------
    localparam int unsigned APB_ADDR_W = 12;
    localparam logic [11:0] APB_CTRL = 12'h000;
    localparam logic [11:0] APB_STATUS = 12'h004;
    localparam logic [11:0] APB_BYTE_BASE = 12'h080;

    localparam int unsigned CTRL_PORT_EN_BIT = 0;
    localparam logic CTRL_PORT_EN_RESET = 1'b1;

    localparam int unsigned ST_MODE8_BIT = 0;
    localparam int unsigned ST_SEL_STRAP_BIT = 1;
    localparam int unsigned ST_CLK_STRAP_BIT = 2;
    localparam int unsigned ST_BCB_BIT = 3;
    localparam int unsigned ST_PAGE_LSB = 4;
    localparam int unsigned ST_BURST_BIT = 6;
    localparam int unsigned ST_READY_BIT = 7;

    typedef enum logic [1:0] {ST_IDLE, ST_READ, ST_WRITE} port_state_t;

endpackage : host_port_pkg

// >>> rtl/host_evt_if.sv
// carrier between the pin synchroniser and the host port core
`timescale 1ns/1ps
`default_nettype none
interface host_evt_if;
    logic rd_act;
    logic wr_act;
    logic [5:0] addr;
    logic [15:0] wdata;
    logic bound_toggle;
    logic bcb_sel;

    modport sync (output rd_act, output wr_act, output addr, output wdata, output bound_toggle, input bcb_sel);
    modport core (input rd_act, input wr_act, input addr, input wdata, input bound_toggle, output bcb_sel);
endinterface : host_evt_if
`default_nettype wire

// >>> rtl/host_pin_sync.sv
// two-flop synchroniser for the host pins and word boundary detector
`timescale 1ns/1ps
`default_nettype none
module host_pin_sync (
    input wire logic pclk, // system clock
    input wire logic presetn, // async reset, active low
    input wire logic cs_n, // host chip select pin
    input wire logic rd_n, // host read strobe pin
    input wire logic wr_n, // host write strobe pin
    input wire logic [5:0] addr, // host address pins
    input wire logic [15:0] data, // host data pins, input side
    host_evt_if.sync evt // synchronised view
);
    import host_port_pkg::*;

    logic [PIN_W-1:0] meta;
    logic [PIN_W-1:0] stable;
    logic [1:0] prev_low_addr;

    wire [PIN_W-1:0] pins = {cs_n, rd_n, wr_n, addr, data};
    wire [1:0] low_addr = stable[DATA_W+1:DATA_W];

    // ------------------------------------------------------------
    // synchroniser; meta feeds stable and nothing else
    // ------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            meta <= '1;
            stable <= '1;
            prev_low_addr <= 2'h3;
        end else begin
            meta <= pins;
            stable <= meta;
            prev_low_addr <= low_addr;
        end
    end

    assign evt.rd_act = !stable[PIN_W-1] && !stable[PIN_W-2];
    assign evt.wr_act = !stable[PIN_W-1] && !stable[PIN_W-3];
    assign evt.addr = stable[DATA_W+ADDR_W-1:DATA_W];
    assign evt.wdata = stable[DATA_W-1:0];
    // a change of the chosen address bit opens the next burst word
    assign evt.bound_toggle = evt.bcb_sel ? (low_addr[1] ^ prev_low_addr[1])
                                          : (low_addr[0] ^ prev_low_addr[0]);
endmodule : host_pin_sync
`default_nettype wire

// >>> rtl/host_port_byte_map_burst_read.sv
// host port core: 8-bit byte map, data port, burst reads, apb status
//
// Local design decisions: the register addresses and register access over APB.
`timescale 1ns/1ps
`default_nettype none
module host_port_byte_map_burst_read (
    input wire logic pclk, // apb clock, 100 MHz
    input wire logic presetn, // async reset, active low
    input wire logic [host_port_pkg::APB_ADDR_W-1:0] paddr, // apb address
    input wire logic psel, // apb select
    input wire logic penable, // apb enable
    input wire logic pwrite, // apb direction
    input wire logic [31:0] pwdata, // apb write data
    output logic [31:0] prdata, // apb read data
    output logic pready, // apb ready
    output logic pslverr, // apb error, unmapped address
    input wire logic host_cs_n, // host chip select pin
    input wire logic host_rd_n, // host read strobe pin
    input wire logic host_wr_n, // host write strobe pin
    input wire logic [host_port_pkg::ADDR_W-1:0] host_addr, // host address pins
    input wire logic [host_port_pkg::DATA_W-1:0] host_data_in, // host data pins, input
    output logic [host_port_pkg::DATA_W-1:0] host_data_out, // host data pins, output
    output logic host_data_oe, // host data drive enable
    input wire logic eeprom_select_strap, // bus mode strap
    input wire logic eeprom_clock_strap, // bus mode strap
    output logic dp_rd_stb, // packet data port pop
    output logic dp_wr_stb, // packet data port push
    output logic [host_port_pkg::BYTE_W-1:0] dp_wdata, // packet data port write byte
    input wire logic [host_port_pkg::DATA_W-1:0] dp_rdata, // packet data port head word
    output logic soft_reset // device reset pulse
);
    import host_port_pkg::*;

    host_evt_if evt ();

    host_pin_sync u_sync (
        .pclk(pclk),
        .presetn(presetn),
        .cs_n(host_cs_n),
        .rd_n(host_rd_n),
        .wr_n(host_wr_n),
        .addr(host_addr),
        .data(host_data_in),
        .evt(evt)
    );

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    port_state_t state;
    port_state_t next_state;
    logic [BYTE_W-1:0] offs [NUM_OFFS];
    logic bcb;
    logic port_en;
    logic [1:0] strap_meta;
    logic [1:0] strap_sync;
    logic [1:0] straps;
    logic [1:0] take_cnt;
    logic straps_taken;

    // ------------------------------------------------------------
    // read lane mapping
    // ------------------------------------------------------------
    function automatic logic [DATA_W-1:0] map_read(
        input logic [4:0] off,
        input logic [BYTE_W-1:0] own,
        input logic [BYTE_W-1:0] odd,
        input logic [DATA_W-1:0] port_word
    );
        logic [DATA_W-1:0] w;
        w = '0;
        if (off == OFF_DATA_PORT) begin
            w = port_word;
        end else if (off == OFF_UNUSED || off == OFF_RESET) begin
            w = '0;
        end else if (off == OFF_LOW_ONLY) begin
            w = {8'h00, own};
        end else if (off[0]) begin
            w = {own, own};
        end else begin
            w = {odd, own};
        end
        return w;
    endfunction : map_read

    // ------------------------------------------------------------
    // host decode
    // ------------------------------------------------------------
    wire [4:0] off = evt.addr[4:0];
    wire burst = evt.addr[FIFO_SEL_BIT];
    wire [1:0] page = offs[OFF_CMD][PAGE_MSB:PAGE_LSB];
    wire mode_8bit = straps_taken && straps == 2'b11;
    wire host_ok = port_en && mode_8bit;
    wire rd_begin = state == ST_IDLE && evt.rd_act && host_ok;
    // no word count is kept, so a burst never runs out
    wire word_next = state == ST_READ && burst && evt.rd_act && evt.bound_toggle;
    wire fetch = rd_begin || word_next;
    wire wr_begin = state == ST_IDLE && evt.wr_act && !evt.rd_act && host_ok;
    wire wr_commit = state == ST_WRITE && !evt.wr_act;
    wire reset_hit = fetch && off == OFF_RESET;
    wire wr_to_reg = wr_commit && off != OFF_DATA_PORT && off != OFF_UNUSED;
    wire wr_bcb = wr_to_reg && off == OFF_BCB && page == PAGE_BCB;
    wire [DATA_W-1:0] rd_word = map_read(off, offs[off], offs[{off[4:1], 1'b1}], dp_rdata);

    assign evt.bcb_sel = bcb;

    always_comb begin
        next_state = state;
        case (state)
            ST_IDLE: begin
                if (rd_begin) begin
                    next_state = ST_READ;
                end else if (wr_begin) begin
                    next_state = ST_WRITE;
                end
            end
            ST_READ: begin
                if (!evt.rd_act) begin
                    next_state = ST_IDLE;
                end
            end
            ST_WRITE: begin
                if (!evt.wr_act) begin
                    next_state = ST_IDLE;
                end
            end
            default: begin
                next_state = ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state <= ST_IDLE;
        end else begin
            state <= next_state;
        end
    end

    // ------------------------------------------------------------
    // strap capture after reset release
    // ------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            strap_meta <= 2'h0;
            strap_sync <= 2'h0;
            straps <= 2'h0;
            take_cnt <= 2'h0;
            straps_taken <= 1'b0;
        end else begin
            strap_meta <= {eeprom_select_strap, eeprom_clock_strap};
            strap_sync <= strap_meta;
            if (!straps_taken) begin
                take_cnt <= take_cnt + 2'h1;
                if (take_cnt == STRAP_TAKE_CYCLES - 2'h1) begin
                    straps <= strap_sync;
                    straps_taken <= 1'b1;
                end
            end
        end
    end

    // ------------------------------------------------------------
    // byte registers, burst select, data port strobes
    // ------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            for (int i = 0; i < NUM_OFFS; i++) begin
                offs[i] <= OFFS_RESET;
            end
            bcb <= BCB_RESET;
        end else if (reset_hit) begin
            for (int i = 0; i < NUM_OFFS; i++) begin
                offs[i] <= OFFS_RESET;
            end
            bcb <= BCB_RESET;
        end else if (wr_to_reg) begin
            offs[off] <= evt.wdata[BYTE_W-1:0];
            if (wr_bcb) begin
                bcb <= evt.wdata[BCB_BIT];
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            host_data_out <= '0;
            host_data_oe <= 1'b0;
            dp_rd_stb <= 1'b0;
            dp_wr_stb <= 1'b0;
            dp_wdata <= '0;
            soft_reset <= 1'b0;
        end else begin
            if (fetch) begin
                host_data_out <= rd_word;
            end
            host_data_oe <= next_state == ST_READ;
            dp_rd_stb <= fetch && off == OFF_DATA_PORT;
            dp_wr_stb <= wr_commit && off == OFF_DATA_PORT;
            if (wr_commit && off == OFF_DATA_PORT) begin
                dp_wdata <= evt.wdata[BYTE_W-1:0];
            end
            soft_reset <= reset_hit;
        end
    end

    // ------------------------------------------------------------
    // apb slave, zero wait states
    // ------------------------------------------------------------
    wire apb_setup = psel && !penable;
    wire apb_wr = psel && penable && pwrite;
    wire hit_ctrl = paddr == APB_CTRL;
    wire hit_status = paddr == APB_STATUS;
    wire hit_byte = paddr[11:7] == APB_BYTE_BASE[11:7] && paddr[1:0] == 2'h0;
    // straps is {select, clock}: select lands on bit 1, clock on bit 2, straps taken on top
    wire [31:0] status_word = {24'h0, straps_taken, state == ST_READ && burst, page,
                               bcb, straps[0], straps[1], mode_8bit};

    assign pready = 1'b1;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            port_en <= CTRL_PORT_EN_RESET;
        end else if (apb_wr && hit_ctrl) begin
            port_en <= pwdata[CTRL_PORT_EN_BIT];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= '0;
            pslverr <= 1'b0;
        end else if (apb_setup) begin
            pslverr <= !(hit_ctrl || hit_status || hit_byte);
            if (hit_ctrl) begin
                prdata <= {31'h0, port_en};
            end else if (hit_status) begin
                prdata <= status_word;
            end else if (hit_byte) begin
                prdata <= {24'h0, offs[paddr[6:2]]};
            end else begin
                prdata <= '0;
            end
        end
    end

endmodule : host_port_byte_map_burst_read
`default_nettype wire

// >>> tb/host_port_monitor.sv
// assertion checker on the host port top-level pins
`timescale 1ns/1ps
`default_nettype none
module host_port_monitor (
    input wire logic pclk, // clock
    input wire logic presetn, // reset
    input wire logic [host_port_pkg::APB_ADDR_W-1:0] paddr, // apb address
    input wire logic psel, // select
    input wire logic penable, // enable
    input wire logic pslverr, // error
    input wire logic host_rd_n, // read strobe
    input wire logic [host_port_pkg::ADDR_W-1:0] host_addr, // address
    input wire logic [host_port_pkg::DATA_W-1:0] host_data_in, // write lanes
    input wire logic [host_port_pkg::DATA_W-1:0] host_data_out, // read lanes
    input wire logic host_data_oe, // read drive
    input wire logic dp_rd_stb, // port pop
    input wire logic dp_wr_stb, // port push
    input wire logic [host_port_pkg::BYTE_W-1:0] dp_wdata, // port byte
    input wire logic soft_reset // reset pulse
);
    import host_port_pkg::*;
    wire mapped = paddr == APB_CTRL || paddr == APB_STATUS || (paddr[11:7] == 5'h01 && paddr[1:0] == 2'h0);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    apb_error_a: assert property (psel && penable |-> pslverr == !mapped)
        else $error("apb error flag disagrees with the map");
    reset_pulse_a: assert property (soft_reset |=> !soft_reset)
        else $error("device reset pulse too long");
    reset_read_a: assert property (soft_reset |->
        host_data_oe && host_data_out == 16'h0000 && host_addr[4:0] == OFF_RESET)
        else $error("device reset without a read of its offset");
    odd_lanes_a: assert property ($rose(host_data_oe) && host_addr[0] |->
        host_data_out[15:8] == host_data_out[7:0])
        else $error("odd read lanes differ");
    high_lane_a: assert property ($rose(host_data_oe) && host_addr[4:0] == OFF_LOW_ONLY |->
        host_data_out[15:8] == 8'h00)
        else $error("high lane not empty");
    unused_read_a: assert property ($rose(host_data_oe) && host_addr[4:0] == OFF_UNUSED |->
        host_data_out == 16'h0000)
        else $error("unused offset returned data");
    port_pop_a: assert property (dp_rd_stb |->
        !host_rd_n && $past(host_addr[4:0], 2) == OFF_DATA_PORT)
        else $error("data port popped outside a port read");
    port_push_a: assert property (dp_wr_stb |->
        dp_wdata == host_data_in[7:0] && host_addr[4:0] == OFF_DATA_PORT)
        else $error("data port push with wrong byte");
    cover property (soft_reset);
    cover property (dp_rd_stb ##[1:20] dp_rd_stb);
    cover property (dp_wr_stb);
endmodule : host_port_monitor
bind host_port_byte_map_burst_read host_port_monitor u_host_port_monitor (
    .pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable), .pslverr(pslverr),
    .host_rd_n(host_rd_n), .host_addr(host_addr), .host_data_in(host_data_in), .host_data_out(host_data_out),
    .host_data_oe(host_data_oe), .dp_rd_stb(dp_rd_stb), .dp_wr_stb(dp_wr_stb), .dp_wdata(dp_wdata),
    .soft_reset(soft_reset));
`default_nettype wire

// >>> tb/host_cpu_model.sv
// behavioural host processor on the parallel host bus
`timescale 1ns/1ps
`default_nettype none
module host_cpu_model (
    input wire logic pclk, // pacing clock
    output logic cs_n, // chip select
    output logic rd_n, // read strobe
    output logic wr_n, // write strobe
    output logic [5:0] addr, // bit 5 is the burst select
    output logic [15:0] data // write lanes
);
    initial {cs_n, rd_n, wr_n, addr, data} = {3'b111, 22'h00_0000};
    // ------------------------------------------------------------
    // bus cycles, each launched just after a clock edge
    // ------------------------------------------------------------
    task automatic wr(input logic [5:0] a, input logic [15:0] d);
        @(posedge pclk);
        {cs_n, wr_n, addr, data} <= {2'b00, a, d};
        repeat (4) @(posedge pclk);
        {cs_n, wr_n} <= 2'b11;
        // lanes held past the strobe rise to cover the pin sync lag
        repeat (6) @(posedge pclk);
        data <= ~d;
        repeat (3) @(posedge pclk);
    endtask : wr
    task automatic rd_go(input logic [5:0] a);
        @(posedge pclk);
        {cs_n, rd_n, addr} <= {2'b00, a};
        repeat (8) @(posedge pclk);
    endtask : rd_go
    task automatic rd_move(input logic [5:0] a);
        @(posedge pclk);
        addr <= a;
        repeat (8) @(posedge pclk);
    endtask : rd_move
    task automatic rd_stop();
        @(posedge pclk);
        {cs_n, rd_n} <= 2'b11;
        repeat (6) @(posedge pclk);
    endtask : rd_stop
endmodule : host_cpu_model
`default_nettype wire

// >>> tb/host_port_byte_map_burst_read_tb.sv
// self-checking bench for the host port byte map with burst reads
`timescale 1ns/1ps
`default_nettype none
`define CHK(got, want) begin cmp_count++; if ((got) !== (want)) begin n_fail++; $display("unexpected at %0t: %h, expected %h", $time, got, want); end end
module host_port_byte_map_burst_read_tb;
    import host_port_pkg::*;
    logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, bcb = 1'b0, oe_q = 1'b0;
    logic strap = 1'b1;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0000_0000, prdata;
    logic pready, pslverr, cs_n, rd_n, wr_n, oe, dp_rd_stb, dp_wr_stb, soft_reset;
    logic [5:0] haddr;
    logic [15:0] hdin, hdout, out_q, dp_rdata = 16'hA500, exp_dp = 16'hA500, seed = 16'hD80C;
    logic [7:0] dp_wdata, b [32] = '{default: 8'h00};
    logic [32:0] e;
    logic [32:0] hq [$], aq [$], wq [$];
    int n_fail = 0, cmp_count = 0;
    always #5 pclk = ~pclk;
    host_port_byte_map_burst_read u_host_port_byte_map_burst_read (
        .pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite),
        .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .host_cs_n(cs_n),
        .host_rd_n(rd_n), .host_wr_n(wr_n), .host_addr(haddr), .host_data_in(hdin), .host_data_out(hdout),
        .host_data_oe(oe), .eeprom_select_strap(strap), .eeprom_clock_strap(strap), .dp_rd_stb(dp_rd_stb),
        .dp_wr_stb(dp_wr_stb), .dp_wdata(dp_wdata), .dp_rdata(dp_rdata), .soft_reset(soft_reset));
    host_cpu_model u_host_cpu_model (.pclk(pclk), .cs_n(cs_n), .rd_n(rd_n), .wr_n(wr_n), .addr(haddr), .data(hdin));
    // ------------------------------------------------------------
    // output watcher: oldest note against each result that appears
    // ------------------------------------------------------------
    always @(posedge pclk) begin
        oe_q <= oe;
        out_q <= hdout;
        if (dp_rd_stb === 1'b1) dp_rdata <= dp_rdata + 16'h0001;
        if (oe === 1'b1 && (oe_q !== 1'b1 || hdout !== out_q)) begin
            e = hq.size() != 0 ? hq.pop_front() : 33'hX;
            `CHK(33'(hdout), e)
        end
        if (psel && penable && pready === 1'b1 && !pwrite) begin
            e = aq.size() != 0 ? aq.pop_front() : 33'hX;
            `CHK({pslverr, prdata}, e)
        end
        if (dp_wr_stb === 1'b1) begin
            e = wq.size() != 0 ? wq.pop_front() : 33'hX;
            `CHK(33'(dp_wdata), e)
        end
    end
    function automatic logic [15:0] lfsr(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction : lfsr
    function automatic logic [32:0] stat();
        return {25'h0, 1'b1, 1'b0, b[0][7:6], bcb, 3'b111};
    endfunction : stat
    function automatic logic [15:0] rexp(input logic [4:0] o);
        logic [15:0] r;
        r = o[0] ? {b[o], b[o]} : {b[o + 5'd1], b[o]};
        if (o == OFF_LOW_ONLY) r = {8'h00, b[o]};
        if (o == OFF_UNUSED || o == OFF_RESET) r = 16'h0000;
        if (o == OFF_DATA_PORT) begin
            r = exp_dp;
            exp_dp = exp_dp + 16'h0001;
        end
        return r;
    endfunction : rexp
    task automatic tally_and_finish();
        if (hq.size() + aq.size() + wq.size() != 0) n_fail++;
        $display("comparisons %0d, mismatches %0d", cmp_count, n_fail);
        if (n_fail == 0 && cmp_count > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : tally_and_finish
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d, input logic [32:0] ex);
        int n;
        if (!w) aq.push_back(ex);
        @(posedge pclk);
        {psel, pwrite, paddr, pwdata} <= {1'b1, w, a, d};
        @(posedge pclk);
        penable <= 1'b1;
        for (n = 0; n < 16; n++) begin
            @(posedge pclk);
            if (pready === 1'b1) break;
        end
        {psel, penable} <= 2'b00;
        if (n == 16) begin
            n_fail++;
            tally_and_finish();
        end
    endtask : apb
    task automatic hwr(input logic [5:0] a, input logic [15:0] d);
        if (a[4:0] == OFF_DATA_PORT) wq.push_back(d[7:0]);
        else if (a[4:0] != OFF_UNUSED) b[a[4:0]] = d[7:0];
        if (a[4:0] == OFF_BCB && b[0][7:6] == PAGE_BCB) bcb = d[0];
        u_host_cpu_model.wr(a, d);
    endtask : hwr
    task automatic hrd(input logic [5:0] a);
        hq.push_back(rexp(a[4:0]));
        u_host_cpu_model.rd_go(a);
        u_host_cpu_model.rd_stop();
        if (a[4:0] == OFF_RESET) begin
            b = '{default: 8'h00};
            bcb = 1'b0;
        end
    endtask : hrd
    // nine words while strobe held: the chosen address bit toggles
    task automatic burst(input logic [5:0] a0, input logic [5:0] a1);
        hq.push_back(rexp(a0[4:0]));
        u_host_cpu_model.rd_go(a0);
        for (int i = 1; i < 9; i++) begin
            hq.push_back(rexp(i[0] ? a1[4:0] : a0[4:0]));
            u_host_cpu_model.rd_move(i[0] ? a1 : a0);
        end
        u_host_cpu_model.rd_stop();
    endtask : burst
    initial begin
        repeat (20000) @(posedge pclk);
        n_fail++;
        tally_and_finish();
    end
    initial begin
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        repeat (5) @(posedge pclk);
        apb(1'b0, APB_CTRL, 32'h0, {1'b0, 32'h0000_0001});
        apb(1'b1, APB_CTRL, 32'h0, 33'h0);
        apb(1'b0, APB_CTRL, 32'h0, {1'b0, 32'h0000_0000});
        // port disabled: any drive of the lanes now finds no note and counts as a mismatch
        u_host_cpu_model.rd_go(6'h01);
        u_host_cpu_model.rd_stop();
        apb(1'b1, APB_CTRL, 32'h1, 33'h0);
        apb(1'b1, APB_STATUS, 32'hFF, 33'h0);
        apb(1'b0, APB_STATUS, 32'h0, stat());
        apb(1'b0, 12'h008, 32'h0, {1'b1, 32'h0000_0000});
        $display("test registers done");
        for (int i = 0; i < 32; i++) begin
            seed = lfsr(seed);
            hwr({seed[15], i[4:0]}, seed);
        end
        for (int i = 0; i < 32; i++) apb(1'b0, APB_BYTE_BASE + 12'(4 * i), 32'h0, {25'h0, b[i]});
        $display("test lane writes done");
        for (int i = 0; i < 31; i++) begin
            seed = lfsr(seed);
            hrd({seed[0], i[4:0]});
        end
        $display("test byte map reads done");
        hwr(6'h00, 16'h3CC0);
        hwr(6'h0D, 16'hC301);
        apb(1'b0, APB_STATUS, 32'h0, stat());
        burst(6'h30, 6'h32);
        hwr(6'h2D, 16'hFF00);
        burst(6'h30, 6'h31);
        $display("test bursts done");
        hrd(6'h1F);
        apb(1'b0, APB_BYTE_BASE, 32'h0, 33'h0);
        apb(1'b0, APB_STATUS, 32'h0, stat());
        hwr(6'h1F, 16'hA55A);
        apb(1'b0, APB_BYTE_BASE + 12'h07C, 32'h0, {25'h0, 8'h5A});
        $display("test device reset done");
        // second reset with the straps low: the port must come up inert
        strap <= 1'b0;
        presetn <= 1'b0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        repeat (5) @(posedge pclk);
        apb(1'b0, APB_STATUS, 32'h0, {25'h0, 8'h80});
        u_host_cpu_model.rd_go(6'h02);
        u_host_cpu_model.rd_stop();
        $display("test strap refusal done");
        tally_and_finish();
    end
endmodule : host_port_byte_map_burst_read_tb
`default_nettype wire
